// [core/operand_and_jump_address_gen.sv]
// How it works
// - one data space; ram bytes at 00 to 6F, accumulator and counter outside.
// - reads of 70 to 7F give all ones; other unused reads give zero.
// - F0 to FB register ram; FC second pointer, FD stack, FE first pointer.
// - eleven modes: six operand modes and five control transfer modes.
// - indirect operand is the byte addressed by the chosen pointer.
// - auto-modify variant steps the chosen pointer up or down after access.
// - direct mode takes the operand address from an 8-bit field.
// - immediate mode operand is the 8-bit instruction field.
// - short immediate loads first pointer from a 4-bit field.
// - table lookup reads program memory at upper counter bits and accumulator.
// - short relative jump adds displacement, allowed -31 to +32.
// - displacement plus one acts as no operation.
// - relative target uses all 15 counter bits, no paging.
// - absolute jump or call replaces low 12 counter bits.
// - long jump or call replaces the whole counter.
// - indirect jump reads a byte at upper counter bits and accumulator, loads counter low byte.
// - vector dispatch fetches two adjacent bytes into the counter.
// - counter is 15 bits, 7 upper and 8 lower.
// - register operands address F0 to FE including pointers and stack.
`timescale 1ns/1ps
`default_nettype none

module operand_and_jump_address_gen (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 cmd_valid,
  input  wire agen_pkg::op_t        cmd_op,
  input  wire logic                 ptr_sel,
  input  wire logic                 mod_dec,
  input  wire logic                 store_en,
  input  wire logic [7:0]           store_data,
  input  wire logic [7:0]           direct_addr,
  input  wire logic [7:0]           imm_field,
  input  wire logic [3:0]           short_field,
  input  wire logic [7:0]           acc,
  input  wire logic signed [6:0]    rel_disp,
  input  wire logic [11:0]          abs_field,
  input  wire logic [14:0]          long_field,
  input  wire logic [14:0]          vector_addr,
  input  wire logic [7:0]           rom_data,
  output var  logic                 busy,
  output var  logic                 done,
  output var  logic [7:0]           operand,
  output var  logic                 no_operation,
  output var  logic                 jump_error,
  output var  logic [14:0]          program_counter,
  output var  logic [14:0]          rom_addr,
  output var  logic                 rom_rd
);
  import agen_pkg::*;

  logic [7:0]   main_ram [0:RAM_DEPTH-1];
  logic [7:0]   reg_ram  [0:REGRAM_DEPTH-1];

  state_t       state_q;
  state_t       state_d;
  op_t          op_hold_q;
  op_t          op_hold_d;
  logic         busy_q;
  logic         busy_d;
  logic         done_q;
  logic         done_d;
  logic [7:0]   operand_q;
  logic [7:0]   operand_d;
  logic         nop_q;
  logic         nop_d;
  logic         err_q;
  logic         err_d;
  logic [14:0]  pc_q;
  logic [14:0]  pc_d;
  logic [14:0]  rom_addr_q;
  logic [14:0]  rom_addr_d;
  logic         rom_rd_q;
  logic         rom_rd_d;
  logic         second_q;
  logic         second_d;
  logic [7:0]   vec_hi_q;
  logic [7:0]   vec_hi_d;
  logic [7:0]   first_ptr_q;
  logic [7:0]   first_ptr_d;
  logic [7:0]   second_ptr_q;
  logic [7:0]   second_ptr_d;
  logic [7:0]   stack_ptr_q;
  logic [7:0]   stack_ptr_d;

  logic [7:0]   sel_ptr;
  logic [7:0]   eff_addr;
  logic [7:0]   rd_val;
  logic [7:0]   stepped_ptr;
  logic [14:0]  rel_ext;
  logic [14:0]  page_addr;
  logic         ram_we;
  logic         reg_we;

  assign busy            = busy_q;
  assign done            = done_q;
  assign operand         = operand_q;
  assign no_operation    = nop_q;
  assign jump_error      = err_q;
  assign program_counter = pc_q;
  assign rom_addr        = rom_addr_q;
  assign rom_rd          = rom_rd_q;

  // address forming and data space decode
  always_comb begin
    sel_ptr     = ptr_sel ? second_ptr_q : first_ptr_q;
    eff_addr    = (cmd_op == OP_DIRECT) ? direct_addr : sel_ptr;
    stepped_ptr = sel_ptr + (mod_dec ? PTR_DEC : PTR_INC);
    rel_ext     = {{8{rel_disp[6]}}, rel_disp};
    page_addr   = {pc_q[14:8], acc};
    if (eff_addr <= RAM_LAST) begin
      rd_val = main_ram[eff_addr[6:0]];
    end else if (eff_addr <= ONES_LAST) begin
      rd_val = READ_ONES;
    end else if ((eff_addr >= REGRAM_FIRST) && (eff_addr <= REGRAM_LAST)) begin
      rd_val = reg_ram[eff_addr[3:0]];
    end else if (eff_addr == ADDR_SECOND) begin
      rd_val = second_ptr_q;
    end else if (eff_addr == ADDR_STACK) begin
      rd_val = stack_ptr_q;
    end else if (eff_addr == ADDR_FIRST) begin
      rd_val = first_ptr_q;
    end else begin
      // peripheral space lives elsewhere; zero keeps reads deterministic
      rd_val = READ_UNDEF;
    end
  end

  // sequencing, pointers and program counter
  always_comb begin
    state_d      = state_q;
    op_hold_d    = op_hold_q;
    busy_d       = busy_q;
    done_d       = 1'b0;
    operand_d    = operand_q;
    nop_d        = 1'b0;
    err_d        = 1'b0;
    pc_d         = pc_q;
    rom_addr_d   = rom_addr_q;
    rom_rd_d     = 1'b0;
    second_d     = second_q;
    vec_hi_d     = vec_hi_q;
    first_ptr_d  = first_ptr_q;
    second_ptr_d = second_ptr_q;
    stack_ptr_d  = stack_ptr_q;
    ram_we       = 1'b0;
    reg_we       = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (cmd_valid) begin
          done_d = 1'b1;
          case (cmd_op)
            OP_PTR_INDIRECT, OP_PTR_INDIRECT_MOD, OP_DIRECT: begin
              // store returns the old byte, which serves the exchange form
              operand_d = rd_val;
              if (store_en) begin
                if (eff_addr <= RAM_LAST) begin
                  ram_we = 1'b1;
                end else if ((eff_addr >= REGRAM_FIRST) && (eff_addr <= REGRAM_LAST)) begin
                  reg_we = 1'b1;
                end else if (eff_addr == ADDR_SECOND) begin
                  second_ptr_d = store_data;
                end else if (eff_addr == ADDR_STACK) begin
                  stack_ptr_d = store_data;
                end else if (eff_addr == ADDR_FIRST) begin
                  first_ptr_d = store_data;
                end
              end
              // step after the access; it overrides a store to the same pointer
              if (cmd_op == OP_PTR_INDIRECT_MOD) begin
                if (ptr_sel) begin
                  second_ptr_d = stepped_ptr;
                end else begin
                  first_ptr_d = stepped_ptr;
                end
              end
            end
            OP_IMMEDIATE: begin
              operand_d = imm_field;
            end
            OP_SHORT_IMMEDIATE: begin
              operand_d   = {SHORT_PAD, short_field};
              first_ptr_d = {SHORT_PAD, short_field};
            end
            OP_TABLE_LOOKUP_LOAD, OP_INDIRECT_JUMP: begin
              done_d     = 1'b0;
              busy_d     = 1'b1;
              op_hold_d  = cmd_op;
              rom_addr_d = page_addr;
              rom_rd_d   = 1'b1;
              state_d    = S_REQ;
            end
            OP_VECTORED_INTERRUPT_DISPATCH: begin
              done_d     = 1'b0;
              busy_d     = 1'b1;
              op_hold_d  = cmd_op;
              second_d   = 1'b0;
              rom_addr_d = vector_addr;
              rom_rd_d   = 1'b1;
              state_d    = S_REQ;
            end
            OP_SHORT_RELATIVE_JUMP: begin
              if (rel_disp == REL_NOP) begin
                nop_d = 1'b1;
                pc_d  = pc_q + PC_STEP;
              end else if ((rel_disp < REL_MIN) || (rel_disp > REL_MAX)) begin
                err_d = 1'b1;
              end else begin
                pc_d = pc_q + rel_ext;
              end
            end
            OP_ABSOLUTE_JUMP: begin
              pc_d = {pc_q[14:12], abs_field};
            end
            OP_LONG_JUMP: begin
              pc_d = long_field;
            end
            default: begin
              err_d = 1'b1;
            end
          endcase
        end
      end
      S_REQ: begin
        // rom latches the address on this edge, data is valid next cycle
        state_d = S_DATA;
      end
      S_DATA: begin
        state_d = S_IDLE;
        busy_d  = 1'b0;
        done_d  = 1'b1;
        case (op_hold_q)
          OP_TABLE_LOOKUP_LOAD: begin
            operand_d = rom_data;
          end
          OP_INDIRECT_JUMP: begin
            pc_d = {pc_q[14:8], rom_data};
          end
          OP_VECTORED_INTERRUPT_DISPATCH: begin
            if (!second_q) begin
              vec_hi_d   = rom_data;
              second_d   = 1'b1;
              rom_addr_d = rom_addr_q + VEC_STEP;
              rom_rd_d   = 1'b1;
              state_d    = S_REQ;
              busy_d     = 1'b1;
              done_d     = 1'b0;
            end else begin
              pc_d = {vec_hi_q[6:0], rom_data};
            end
          end
          default: begin
            err_d = 1'b1;
          end
        endcase
      end
      default: begin
        state_d = S_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= S_IDLE;
      op_hold_q    <= OP_PTR_INDIRECT;
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      operand_q    <= READ_UNDEF;
      nop_q        <= 1'b0;
      err_q        <= 1'b0;
      pc_q         <= PC_RESET;
      rom_addr_q   <= PC_RESET;
      rom_rd_q     <= 1'b0;
      second_q     <= 1'b0;
      vec_hi_q     <= READ_UNDEF;
      first_ptr_q  <= PTR_RESET;
      second_ptr_q <= PTR_RESET;
      stack_ptr_q  <= STACK_RESET;
    end else begin
      state_q      <= state_d;
      op_hold_q    <= op_hold_d;
      busy_q       <= busy_d;
      done_q       <= done_d;
      operand_q    <= operand_d;
      nop_q        <= nop_d;
      err_q        <= err_d;
      pc_q         <= pc_d;
      rom_addr_q   <= rom_addr_d;
      rom_rd_q     <= rom_rd_d;
      second_q     <= second_d;
      vec_hi_q     <= vec_hi_d;
      first_ptr_q  <= first_ptr_d;
      second_ptr_q <= second_ptr_d;
      stack_ptr_q  <= stack_ptr_d;
    end
  end

  // ram contents are not reset, as in the real array
  always_ff @(posedge clk) begin
    if (ram_we) begin
      main_ram[eff_addr[6:0]] <= store_data;
    end
    if (reg_we) begin
      reg_ram[eff_addr[3:0]] <= store_data;
    end
  end

endmodule

`default_nettype wire

// [inc/agen_pkg.sv]
package agen_pkg;

  // data memory map
  localparam logic [7:0]  RAM_LAST      = 8'h6F;
  localparam logic [7:0]  ONES_LAST     = 8'h7F;
  localparam logic [7:0]  REGRAM_FIRST  = 8'hF0;
  localparam logic [7:0]  REGRAM_LAST   = 8'hFB;
  localparam logic [7:0]  ADDR_SECOND   = 8'hFC;
  localparam logic [7:0]  ADDR_STACK    = 8'hFD;
  localparam logic [7:0]  ADDR_FIRST    = 8'hFE;
  localparam int          RAM_DEPTH     = 112;
  localparam int          REGRAM_DEPTH  = 12;

  // read values of unmapped space
  localparam logic [7:0]  READ_ONES     = 8'hFF;
  localparam logic [7:0]  READ_UNDEF    = 8'h00;

  // reset values
  localparam logic [7:0]  STACK_RESET   = 8'h6F;
  localparam logic [7:0]  PTR_RESET     = 8'h00;
  localparam logic [14:0] PC_RESET      = 15'h0000;

  // pointer post modification
  localparam logic [7:0]  PTR_INC       = 8'h01;
  localparam logic [7:0]  PTR_DEC       = 8'hFF;
  localparam logic [3:0]  SHORT_PAD     = 4'h0;

  // short relative jump limits, signed displacement
  localparam logic signed [6:0] REL_MIN = -7'sh1F;
  localparam logic signed [6:0] REL_MAX = 7'sh20;
  localparam logic signed [6:0] REL_NOP = 7'sh01;
  localparam logic [14:0] PC_STEP       = 15'h0001;
  localparam logic [14:0] VEC_STEP      = 15'h0001;

  typedef enum logic [3:0] {
    OP_PTR_INDIRECT                 = 4'h0,
    OP_PTR_INDIRECT_MOD             = 4'h1,
    OP_DIRECT                       = 4'h2,
    OP_IMMEDIATE                    = 4'h3,
    OP_SHORT_IMMEDIATE              = 4'h4,
    OP_TABLE_LOOKUP_LOAD            = 4'h5,
    OP_SHORT_RELATIVE_JUMP          = 4'h6,
    OP_ABSOLUTE_JUMP                = 4'h7,
    OP_LONG_JUMP                    = 4'h8,
    OP_INDIRECT_JUMP                = 4'h9,
    OP_VECTORED_INTERRUPT_DISPATCH  = 4'hA
  } op_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_REQ  = 2'b01,
    S_DATA = 2'b10
  } state_t;

endpackage

// [verif/agen_rom_model.sv]
`timescale 1ns/1ps
`default_nettype none

module agen_rom_model (
  input  wire logic        clk,
  input  wire logic        rom_rd,
  input  wire logic [14:0] rom_addr,
  output var  logic [7:0]  rom_data
);
  initial rom_data = 8'hA5;

  // sync rom: valid one cycle after the read, inverted junk otherwise
  // plain always: the initial value above would be a second driver under always_ff
  always @(posedge clk) begin
    if (rom_rd) begin
      rom_data <= rom_addr[7:0] ^ {1'b0, rom_addr[14:8]} ^ 8'h5A;
    end else begin
      rom_data <= ~rom_data;
    end
  end
endmodule

`default_nettype wire

// [verif/operand_and_jump_address_gen_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module agen_sva
  import agen_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 cmd_valid,
  input wire agen_pkg::op_t        cmd_op,
  input wire logic [7:0]           imm_field,
  input wire logic [3:0]           short_field,
  input wire logic [7:0]           acc,
  input wire logic signed [6:0]    rel_disp,
  input wire logic [11:0]          abs_field,
  input wire logic [14:0]          long_field,
  input wire logic [14:0]          vector_addr,
  input wire logic [7:0]           rom_data,
  input wire logic                 busy,
  input wire logic                 done,
  input wire logic [7:0]           operand,
  input wire logic                 no_operation,
  input wire logic                 jump_error,
  input wire logic [14:0]          program_counter,
  input wire logic [14:0]          rom_addr,
  input wire logic                 rom_rd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic take;
  logic rel_ok;
  assign take   = cmd_valid && !busy;
  assign rel_ok = rel_disp >= REL_MIN && rel_disp <= REL_MAX;

  sequence s_hi_fetch; rom_rd && rom_addr == $past(vector_addr); endsequence
  sequence s_lo_fetch; rom_rd && rom_addr == $past(vector_addr, 3) + VEC_STEP; endsequence
  sequence s_rom_wait; rom_rd ##2 done; endsequence

  property p_single; take && cmd_op inside {[4'h0:4'h4], [4'h6:4'h8]} |=> done && !busy; endproperty
  a_single: assert property (p_single) else $error("single op did not finish in one cycle");
  property p_imm; take && cmd_op == OP_IMMEDIATE |=> operand == $past(imm_field); endproperty
  a_imm: assert property (p_imm) else $error("immediate operand wrong");
  property p_short; take && cmd_op == OP_SHORT_IMMEDIATE |=> operand == {SHORT_PAD, $past(short_field)}; endproperty
  a_short: assert property (p_short) else $error("short immediate wrong");
  property p_abs;
    take && cmd_op == OP_ABSOLUTE_JUMP |=> program_counter == {$past(program_counter[14:12]), $past(abs_field)};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target wrong");
  property p_long; take && cmd_op == OP_LONG_JUMP |=> program_counter == $past(long_field); endproperty
  a_long: assert property (p_long) else $error("long target wrong");
  property p_rel;
    take && cmd_op == OP_SHORT_RELATIVE_JUMP && rel_ok
      |=> program_counter == $past(program_counter) + {{8{$past(rel_disp[6])}}, $past(rel_disp)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_nop; take && cmd_op == OP_SHORT_RELATIVE_JUMP && rel_disp == REL_NOP |=> no_operation; endproperty
  a_nop: assert property (p_nop) else $error("plus one not flagged");
  property p_err;
    take && cmd_op == OP_SHORT_RELATIVE_JUMP && !rel_ok |=> jump_error && $stable(program_counter);
  endproperty
  a_err: assert property (p_err) else $error("out of range jump not refused");
  property p_lut;
    take && cmd_op == OP_TABLE_LOOKUP_LOAD
      |=> rom_rd && rom_addr == {$past(program_counter[14:8]), $past(acc)} ##2 done && operand == $past(rom_data);
  endproperty
  a_lut: assert property (p_lut) else $error("table lookup wrong");
  property p_jid; take && cmd_op == OP_INDIRECT_JUMP |=> s_rom_wait ##0 program_counter[7:0] == $past(rom_data);
  endproperty
  a_jid: assert property (p_jid) else $error("indirect jump wrong");
  property p_vis; take && cmd_op == OP_VECTORED_INTERRUPT_DISPATCH |=> s_hi_fetch ##2 s_lo_fetch ##2 done && !busy;
  endproperty
  a_vis: assert property (p_vis) else $error("vector fetch wrong");
endmodule

bind operand_and_jump_address_gen agen_sva u_sva (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .imm_field(imm_field), .short_field(short_field), .acc(acc), .rel_disp(rel_disp), .abs_field(abs_field),
  .long_field(long_field), .vector_addr(vector_addr), .rom_data(rom_data), .busy(busy), .done(done),
  .operand(operand), .no_operation(no_operation), .jump_error(jump_error), .program_counter(program_counter),
  .rom_addr(rom_addr), .rom_rd(rom_rd));

`default_nettype wire

// [verif/operand_and_jump_address_gen_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module operand_and_jump_address_gen_tb;
  import agen_pkg::*;
  typedef struct {op_t op; logic s, m, w; logic [7:0] a, d, e; logic c;} row_t;
  logic clk, rst, cmd_valid, ptr_sel, mod_dec, store_en, busy, done, no_operation, jump_error, rom_rd;
  logic [7:0] store_data, direct_addr, imm_field, acc, rom_data, operand, hi, lo;
  logic [3:0] short_field;
  logic signed [6:0] rel_disp;
  logic [11:0] abs_field;
  logic [14:0] long_field, vector_addr, program_counter, rom_addr, pc_e;
  op_t cmd_op;
  int error_cnt = 0;
  int cmp_count = 0;
  // old byte comes back on every store, so the row after a store sees it
  row_t rows [18] = '{'{OP_DIRECT,0,0,1,8'h10,8'h3C,8'h00,0}, '{OP_DIRECT,0,0,1,8'h10,8'h77,8'h3C,1},
    '{OP_DIRECT,0,0,1,8'h6F,8'h5A,8'h00,0}, '{OP_DIRECT,0,0,0,8'h6F,8'h00,8'h5A,1},
    '{OP_DIRECT,0,0,1,8'h70,8'h12,8'hFF,1}, '{OP_DIRECT,0,0,0,8'h7F,8'h00,8'hFF,1},
    '{OP_DIRECT,0,0,1,8'hF0,8'hA5,8'h00,0}, '{OP_DIRECT,0,0,0,8'hF0,8'h00,8'hA5,1},
    '{OP_DIRECT,0,0,0,8'hFD,8'h00,8'h6F,1}, '{OP_SHORT_IMMEDIATE,0,0,0,8'h00,8'h0F,8'h0F,1},
    '{OP_DIRECT,0,0,0,8'hFE,8'h00,8'h0F,1}, '{OP_DIRECT,0,0,1,8'hFC,8'h10,8'h00,1},
    '{OP_PTR_INDIRECT,1,0,0,8'h00,8'h00,8'h77,1}, '{OP_PTR_INDIRECT_MOD,1,0,0,8'h00,8'h00,8'h77,1},
    '{OP_DIRECT,0,0,0,8'hFC,8'h00,8'h11,1}, '{OP_SHORT_IMMEDIATE,0,0,0,8'h00,8'h00,8'h00,1},
    '{OP_PTR_INDIRECT_MOD,0,1,0,8'h00,8'h00,8'h00,0}, '{OP_DIRECT,0,0,0,8'hFE,8'h00,8'hFF,1}};

  operand_and_jump_address_gen dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .ptr_sel(ptr_sel), .mod_dec(mod_dec), .store_en(store_en), .store_data(store_data), .direct_addr(direct_addr),
    .imm_field(imm_field), .short_field(short_field), .acc(acc), .rel_disp(rel_disp), .abs_field(abs_field),
    .long_field(long_field), .vector_addr(vector_addr), .rom_data(rom_data), .busy(busy), .done(done),
    .operand(operand), .no_operation(no_operation), .jump_error(jump_error), .program_counter(program_counter),
    .rom_addr(rom_addr), .rom_rd(rom_rd));
  agen_rom_model rom (.clk(clk), .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] rom_fn(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5A;
  endfunction

  task automatic chk_val(input string s, input logic [14:0] e, input logic [14:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic chk_bit(input string s, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %b got %b", s, e, g);
    end
  endtask

  task automatic go(input op_t o);
    int n;
    @(posedge clk);
    cmd_op <= o;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit("done", 1'b1, done);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial begin
    {rst, cmd_valid, ptr_sel, mod_dec, store_en} = 5'b10000;
    {store_data, direct_addr, imm_field, acc, short_field, rel_disp} = '0;
    {abs_field, long_field, vector_addr} = '0;
    cmd_op = OP_PTR_INDIRECT;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_val("pc", 15'h0000, program_counter);
    foreach (rows[i]) begin
      {ptr_sel, mod_dec, store_en} <= {rows[i].s, rows[i].m, rows[i].w};
      {store_data, direct_addr, imm_field} <= {rows[i].d, rows[i].a, rows[i].d};
      short_field <= rows[i].d[3:0];
      go(rows[i].op);
      if (rows[i].c) chk_val("operand", {7'h00, rows[i].e}, {7'h00, operand});
    end
    imm_field <= 8'hC3;
    go(OP_IMMEDIATE);
    chk_val("imm", 15'h00C3, {7'h00, operand});
    long_field <= 15'h00F0;
    go(OP_LONG_JUMP);
    chk_val("pc", 15'h00F0, program_counter);
    rel_disp <= 7'sd32;
    go(OP_SHORT_RELATIVE_JUMP);
    chk_val("pc", 15'h0110, program_counter);
    rel_disp <= -7'sd31;
    go(OP_SHORT_RELATIVE_JUMP);
    chk_val("pc", 15'h00F1, program_counter);
    rel_disp <= 7'sd1;
    go(OP_SHORT_RELATIVE_JUMP);
    chk_bit("nop", 1'b1, no_operation);
    chk_val("pc", 15'h00F2, program_counter);
    for (int k = 0; k < 2; k++) begin
      rel_disp <= (k == 0) ? 7'sd33 : -7'sd32;
      go(OP_SHORT_RELATIVE_JUMP);
      chk_bit("err", 1'b1, jump_error);
      chk_val("pc", 15'h00F2, program_counter);
    end
    // undefined op code: refused with an error pulse, counter untouched
    go(op_t'(4'hB));
    chk_bit("err", 1'b1, jump_error);
    chk_val("pc", 15'h00F2, program_counter);
    long_field <= 15'h7123;
    abs_field <= 12'hABC;
    go(OP_LONG_JUMP);
    go(OP_ABSOLUTE_JUMP);
    chk_val("pc", 15'h7ABC, program_counter);
    acc <= 8'h34;
    go(OP_TABLE_LOOKUP_LOAD);
    chk_val("lookup", {7'h00, rom_fn(15'h7A34)}, {7'h00, operand});
    go(OP_INDIRECT_JUMP);
    chk_val("pc", {7'h7A, rom_fn(15'h7A34)}, program_counter);
    vector_addr <= 15'h12FF;
    go(OP_VECTORED_INTERRUPT_DISPATCH);
    hi = rom_fn(15'h12FF);
    lo = rom_fn(15'h1300);
    chk_val("pc", {hi[6:0], lo}, program_counter);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_val("pc", 15'h0000, program_counter);
    close_out();
  end
endmodule

`default_nettype wire
